/* File: hdl/tmr_pkg.sv */
package tmr_pkg;
  // Register byte addresses on the internal register bus.
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h6F;
  localparam logic [7:0] ADDR_FLAGS = 8'h36;
  localparam logic [7:0] ADDR_CLK_CTRL = 8'h81;
  localparam logic [7:0] ADDR_WAVE_CTRL = 8'h80;
  localparam logic [7:0] ADDR_FORCE_CTRL = 8'h82;
  localparam logic [7:0] ADDR_CNT_LO = 8'h84;
  localparam logic [7:0] ADDR_CNT_HI = 8'h85;
  localparam logic [7:0] ADDR_CAP_LO = 8'h86;
  localparam logic [7:0] ADDR_CAP_HI = 8'h87;
  localparam logic [7:0] ADDR_CMPA_LO = 8'h88;
  localparam logic [7:0] ADDR_CMPA_HI = 8'h89;
  localparam logic [7:0] ADDR_CMPB_LO = 8'h8A;
  localparam logic [7:0] ADDR_CMPB_HI = 8'h8B;
  // Field positions.
  localparam int FORCE_A_BIT = 7;
  localparam int FORCE_B_BIT = 6;
  localparam int CAP_IRQ_BIT = 5;
  localparam int CMPB_IRQ_BIT = 2;
  localparam int CMPA_IRQ_BIT = 1;
  localparam int OVF_IRQ_BIT = 0;
  localparam int CAP_EDGE_BIT = 6;
  // Reset values and counter maximum.
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [15:0] RESET_WORD = 16'h0000;
  localparam logic [15:0] COUNT_MAX = 16'hFFFF;
  // Prescaler tap counts.
  localparam int PRESCALE_BITS = 10;
  localparam logic [9:0] DIV8_MASK = 10'h007;
  localparam logic [9:0] DIV64_MASK = 10'h03F;
  localparam logic [9:0] DIV256_MASK = 10'h0FF;
  localparam logic [9:0] DIV1024_MASK = 10'h3FF;
  // Clock select codes.
  typedef enum logic [2:0] {
    CS_STOP = 3'h0, CS_DIV1 = 3'h1, CS_DIV8 = 3'h2, CS_DIV64 = 3'h3,
    CS_DIV256 = 3'h4, CS_DIV1024 = 3'h5, CS_EXT_FALL = 3'h6, CS_EXT_RISE = 3'h7
  } tmr_clk_sel_t;
  // Waveform modes without PWM.
  localparam logic [3:0] WAVE_NORMAL = 4'h0;
  localparam logic [3:0] WAVE_CTC_A = 4'h4;
  localparam logic [3:0] WAVE_CTC_CAP = 4'hC;
endpackage

/* File: hdl/tmr_tick_gen.sv */
`timescale 1ns/1ps
// Produces one-cycle count enables from clock select, prescaler and external pin.
module tmr_tick_gen
  import tmr_pkg::*;
(
  // Clock and reset
  input wire logic clock_i,
  input wire logic rst_b_i,
  // Control
  input wire logic [2:0] clk_sel_i,
  // Pin
  input wire logic ext_pin_i,
  // Tick
  output logic tick_o
);
  logic [PRESCALE_BITS-1:0] pre_q;
  logic sync1_q;
  logic sync2_q;
  logic prev_q;

  always_ff @(posedge clock_i)
  begin
    if (!rst_b_i)
      pre_q <= '0;
    else
      pre_q <= pre_q + 1'b1;
  end

  always_ff @(posedge clock_i)
  begin
    if (!rst_b_i)
    begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
      prev_q <= 1'b0;
    end
    else
    begin
      sync1_q <= ext_pin_i;
      sync2_q <= sync1_q;
      prev_q <= sync2_q;
    end
  end

  always_comb
  begin
    unique case (tmr_clk_sel_t'(clk_sel_i))
      CS_STOP: tick_o = 1'b0; // RULE1
      CS_DIV1: tick_o = 1'b1; // RULE2
      CS_DIV8: tick_o = (pre_q & DIV8_MASK) == DIV8_MASK; // RULE2
      CS_DIV64: tick_o = (pre_q & DIV64_MASK) == DIV64_MASK;
      CS_DIV256: tick_o = (pre_q & DIV256_MASK) == DIV256_MASK;
      CS_DIV1024: tick_o = (pre_q & DIV1024_MASK) == DIV1024_MASK;
      CS_EXT_FALL: tick_o = prev_q & ~sync2_q; // RULE3
      CS_EXT_RISE: tick_o = ~prev_q & sync2_q; // RULE3
    endcase
  end

  a_stop_no_tick: assert property (@(posedge clock_i) disable iff (!rst_b_i) // RULE1
    clk_sel_i == 3'h0 |-> !tick_o) else $error("tick while stopped");
  a_div8_spacing: assert property (@(posedge clock_i) disable iff (!rst_b_i) // RULE2
    (clk_sel_i == 3'h2 && tick_o) ##1 (clk_sel_i == 3'h2) [*8] |-> tick_o)
    else $error("div8 tick spacing wrong");
  a_rise_edge: assert property (@(posedge clock_i) disable iff (!rst_b_i) // RULE3
    (clk_sel_i == 3'h7 && tick_o) |-> sync2_q && !prev_q) else $error("bad rise tick");
endmodule // tmr_tick_gen

/* File: hdl/tmr_regs.sv */
`timescale 1ns/1ps
// Function
// RULE1: Clock select zero stops the counter.
// RULE2: Codes one to five count at clock divided by 1,8,64,256,1024.
// RULE3: Code six counts falling, code seven rising external pin edges.
// RULE4: Force bits act only in non-PWM waveform modes.
// RULE5: A force write strobes an immediate compare match on that channel.
// RULE6: A forced match sets no flag and never clears the counter.
// RULE7: Force bits always read as zero.
// RULE8: Counter is byte accessed with a shared high-byte latch.
// RULE9: A counter write blocks compare matches on the next timer tick.
// RULE10: Software avoids writing the counter while it runs.
// RULE11: Capture events copy the counter into the capture register.
// RULE12: Capture register can serve as counter top.
// RULE13: Capture reads return both bytes from one instant via the latch.
// RULE14: Compare registers match continuously, setting flags and driving outputs.
// RULE15: Compare writes update both bytes together via the latch.
// RULE16: Mask bit 5 with global enable requests the capture interrupt.
// RULE17: Mask bit 2 with global enable requests the compare-B interrupt.
// RULE18: Mask bits 1 and 0 gate compare-A and overflow interrupts.
// RULE19: Flags clear on vector acknowledge or writing one.
// RULE20: Software writes high byte first and reads low byte first.
module tmr_regs
  import tmr_pkg::*;
(
  // Clock and reset
  input wire logic clock_i,
  input wire logic rst_b_i,
  // Register bus
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  // Pins
  input wire logic ext_count_pin_i,
  input wire logic capture_input_pin_i,
  input wire logic comparator_i,
  input wire logic cap_from_comp_i,
  output logic compare_output_pin_a_o,
  output logic compare_output_pin_b_o,
  // Interrupts
  input wire logic global_irq_en_i,
  input wire logic [3:0] irq_ack_i,
  output logic [3:0] irq_req_o
);
  logic [7:0] temp_q;
  logic [15:0] cnt_q;
  logic [15:0] cap_q;
  logic [15:0] cmpa_q;
  logic [15:0] cmpb_q;
  logic [7:0] mask_q;
  logic [7:0] clk_ctrl_q;
  logic [7:0] wave_ctrl_q;
  logic [3:0] flags_q;
  logic block_q;
  logic tick;
  logic [3:0] wave_mode;
  logic non_pwm;
  logic [15:0] top;
  logic cnt_write;
  logic match_a;
  logic match_b;
  logic force_a;
  logic force_b;
  logic cap_s1_q;
  logic cap_s2_q;
  logic cap_prev_q;
  logic cap_event;
  logic cap_is_top;
  logic top_hit;
  logic ovf;
  logic [3:0] flag_set;
  logic [3:0] flag_clr;
  logic comp_s1_q;
  logic comp_s2_q;
  logic cap_src;

  function automatic logic bus_wr(input logic [7:0] a, input logic [7:0] target, input logic w);
    bus_wr = w && (a == target);
  endfunction

  // Output change on a match; mode bits 7:6 (A) and 5:4 (B) of the wave control byte.
  function automatic logic pin_next(input logic cur, input logic [1:0] com);
    unique case (com)
      2'b00: pin_next = cur;
      2'b01: pin_next = ~cur;
      2'b10: pin_next = 1'b0;
      2'b11: pin_next = 1'b1;
    endcase
  endfunction

  tmr_tick_gen u_tick (
    .clock_i(clock_i),
    .rst_b_i(rst_b_i),
    .clk_sel_i(clk_ctrl_q[2:0]),
    .ext_pin_i(ext_count_pin_i),
    .tick_o(tick)
  );

  assign wave_mode = {clk_ctrl_q[4:3], wave_ctrl_q[1:0]};
  assign non_pwm = (wave_mode == WAVE_NORMAL) || (wave_mode == WAVE_CTC_A) || (wave_mode == WAVE_CTC_CAP);
  assign cap_is_top = (wave_mode == WAVE_CTC_CAP) || (wave_mode == 4'hE) || (wave_mode == 4'h8)
    || (wave_mode == 4'hA);
  assign top = cap_is_top ? cap_q : (wave_mode == WAVE_CTC_A) ? cmpa_q : COUNT_MAX; // RULE12
  assign cnt_write = bus_wr(addr_i, ADDR_CNT_LO, wr_i);
  // A counter write masks the compares until the next timer tick, not the next clock.
  assign match_a = tick && !block_q && (cnt_q == cmpa_q); // RULE9 RULE14
  assign match_b = tick && !block_q && (cnt_q == cmpb_q); // RULE9 RULE14
  assign force_a = bus_wr(addr_i, ADDR_FORCE_CTRL, wr_i) && wdata_i[FORCE_A_BIT] && non_pwm; // RULE4 RULE5
  assign force_b = bus_wr(addr_i, ADDR_FORCE_CTRL, wr_i) && wdata_i[FORCE_B_BIT] && non_pwm; // RULE4 RULE5
  assign top_hit = tick && (cnt_q == top);
  // A counter write in the same cycle swallows the overflow.
  assign ovf = top_hit && !cnt_write;
  assign cap_src = cap_from_comp_i ? comp_s2_q : cap_s2_q;
  // The capture input is cut off while the capture register sets the top.
  assign cap_event = !cap_is_top && (clk_ctrl_q[CAP_EDGE_BIT] ? (cap_src && !cap_prev_q) : (!cap_src && cap_prev_q));

  always_ff @(posedge clock_i)
  begin
    if (!rst_b_i)
    begin
      cap_s1_q <= 1'b0;
      cap_s2_q <= 1'b0;
      comp_s1_q <= 1'b0;
      comp_s2_q <= 1'b0;
      cap_prev_q <= 1'b0;
    end
    else
    begin
      cap_s1_q <= capture_input_pin_i;
      cap_s2_q <= cap_s1_q;
      comp_s1_q <= comparator_i;
      comp_s2_q <= comp_s1_q;
      cap_prev_q <= cap_src;
    end
  end

  // Shared high byte: written by high-byte writes, loaded by counter and capture low-byte reads.
  always_ff @(posedge clock_i)
  begin
    if (!rst_b_i)
      temp_q <= RESET_BYTE;
    else if (wr_i && (addr_i == ADDR_CNT_HI || addr_i == ADDR_CAP_HI || addr_i == ADDR_CMPA_HI
      || addr_i == ADDR_CMPB_HI))
      temp_q <= wdata_i; // RULE8 RULE15
    else if (rd_i && addr_i == ADDR_CNT_LO)
      temp_q <= cnt_q[15:8]; // RULE8
    else if (rd_i && addr_i == ADDR_CAP_LO)
      temp_q <= cap_q[15:8]; // RULE13
  end

  always_ff @(posedge clock_i)
  begin
    if (!rst_b_i)
      cnt_q <= RESET_WORD;
    else if (cnt_write)
      cnt_q <= {temp_q, wdata_i}; // RULE8
    else if (tick)
      cnt_q <= (top_hit && wave_mode != WAVE_NORMAL) ? RESET_WORD : cnt_q + 1'b1; // RULE6
  end

  always_ff @(posedge clock_i)
  begin
    if (!rst_b_i)
      block_q <= 1'b0;
    else if (cnt_write)
      block_q <= 1'b1; // RULE9
    else if (tick)
      block_q <= 1'b0;
  end

  always_ff @(posedge clock_i)
  begin
    if (!rst_b_i)
      cap_q <= RESET_WORD;
    else if (bus_wr(addr_i, ADDR_CAP_LO, wr_i))
      cap_q <= {temp_q, wdata_i};
    else if (cap_event)
      cap_q <= cnt_q; // RULE11
  end

  always_ff @(posedge clock_i)
  begin
    if (!rst_b_i)
    begin
      cmpa_q <= RESET_WORD;
      cmpb_q <= RESET_WORD;
    end
    else
    begin
      if (bus_wr(addr_i, ADDR_CMPA_LO, wr_i))
        cmpa_q <= {temp_q, wdata_i}; // RULE15
      if (bus_wr(addr_i, ADDR_CMPB_LO, wr_i))
        cmpb_q <= {temp_q, wdata_i}; // RULE15
    end
  end

  always_ff @(posedge clock_i)
  begin
    if (!rst_b_i)
    begin
      mask_q <= RESET_BYTE;
      clk_ctrl_q <= RESET_BYTE;
      wave_ctrl_q <= RESET_BYTE;
    end
    else
    begin
      if (bus_wr(addr_i, ADDR_IRQ_MASK, wr_i))
        mask_q <= wdata_i & 8'h27;
      if (bus_wr(addr_i, ADDR_CLK_CTRL, wr_i))
        clk_ctrl_q <= wdata_i & 8'hDF;
      if (bus_wr(addr_i, ADDR_WAVE_CTRL, wr_i))
        wave_ctrl_q <= wdata_i & 8'hF3;
    end
  end

  // Bit order: 3 capture, 2 compare B, 1 compare A, 0 overflow.
  assign flag_set = {cap_event || (cap_is_top && top_hit), match_b, match_a, ovf}; // RULE6 RULE14
  assign flag_clr = irq_ack_i | (bus_wr(addr_i, ADDR_FLAGS, wr_i) ?
    {wdata_i[CAP_IRQ_BIT], wdata_i[CMPB_IRQ_BIT], wdata_i[CMPA_IRQ_BIT], wdata_i[OVF_IRQ_BIT]} : 4'h0);

  always_ff @(posedge clock_i)
  begin
    if (!rst_b_i)
      flags_q <= 4'h0;
    else
      flags_q <= flag_set | (flags_q & ~flag_clr); // RULE19
  end

  always_comb
  begin
    irq_req_o[3] = global_irq_en_i && mask_q[CAP_IRQ_BIT] && flags_q[3]; // RULE16
    irq_req_o[2] = global_irq_en_i && mask_q[CMPB_IRQ_BIT] && flags_q[2]; // RULE17
    irq_req_o[1] = global_irq_en_i && mask_q[CMPA_IRQ_BIT] && flags_q[1]; // RULE18
    irq_req_o[0] = global_irq_en_i && mask_q[OVF_IRQ_BIT] && flags_q[0]; // RULE18
  end

  always_ff @(posedge clock_i)
  begin
    if (!rst_b_i)
    begin
      compare_output_pin_a_o <= 1'b0;
      compare_output_pin_b_o <= 1'b0;
    end
    else
    begin
      if (match_a || force_a)
        compare_output_pin_a_o <= pin_next(compare_output_pin_a_o, wave_ctrl_q[7:6]); // RULE5
      if (match_b || force_b)
        compare_output_pin_b_o <= pin_next(compare_output_pin_b_o, wave_ctrl_q[5:4]); // RULE5
    end
  end

  always_ff @(posedge clock_i)
  begin
    if (!rst_b_i)
      rdata_o <= RESET_BYTE;
    else if (rd_i)
    begin
      unique case (addr_i)
        ADDR_IRQ_MASK: rdata_o <= mask_q;
        ADDR_FLAGS: rdata_o <= {2'b00, flags_q[3], 2'b00, flags_q[2:0]};
        ADDR_CLK_CTRL: rdata_o <= clk_ctrl_q;
        ADDR_WAVE_CTRL: rdata_o <= wave_ctrl_q;
        ADDR_FORCE_CTRL: rdata_o <= RESET_BYTE; // RULE7
        ADDR_CNT_LO: rdata_o <= cnt_q[7:0]; // RULE8
        ADDR_CAP_LO: rdata_o <= cap_q[7:0]; // RULE13
        ADDR_CMPA_LO: rdata_o <= cmpa_q[7:0];
        ADDR_CMPA_HI: rdata_o <= cmpa_q[15:8];
        ADDR_CMPB_LO: rdata_o <= cmpb_q[7:0];
        ADDR_CMPB_HI: rdata_o <= cmpb_q[15:8];
        ADDR_CNT_HI, ADDR_CAP_HI: rdata_o <= temp_q; // RULE8 RULE13
        default: rdata_o <= RESET_BYTE;
      endcase
    end
  end

  // Register access and strobe checks.
  a_force_no_flag: assert property (@(posedge clock_i) disable iff (!rst_b_i) // RULE6
    force_a && !match_a && !(flags_q[1]) |=> !flags_q[1]) else $error("force set flag");
  a_force_read_zero: assert property (@(posedge clock_i) disable iff (!rst_b_i) // RULE7
    rd_i && addr_i == ADDR_FORCE_CTRL |=> rdata_o == 8'h00) else $error("force bits read nonzero");
  a_force_pwm_ignored: assert property (@(posedge clock_i) disable iff (!rst_b_i) // RULE4
    !non_pwm && !match_a && !match_b |=> $stable(compare_output_pin_a_o) && $stable(compare_output_pin_b_o))
    else $error("force in pwm");
  a_write_blocks: assert property (@(posedge clock_i) disable iff (!rst_b_i) // RULE9
    cnt_write |=> block_q && !match_a && !match_b) else $error("match after write");
  a_cnt_pair: assert property (@(posedge clock_i) disable iff (!rst_b_i) // RULE8
    cnt_write |=> cnt_q == {$past(temp_q), $past(wdata_i)}) else $error("counter pair wrong");
  a_cap_copy: assert property (@(posedge clock_i) disable iff (!rst_b_i) // RULE11
    cap_event && !bus_wr(addr_i, ADDR_CAP_LO, wr_i) |=> cap_q == $past(cnt_q)) else $error("capture wrong");
  a_cap_hi_atomic: assert property (@(posedge clock_i) disable iff (!rst_b_i) // RULE13
    rd_i && addr_i == ADDR_CAP_LO ##1 !wr_i && !rd_i ##1 rd_i && addr_i == ADDR_CAP_HI
    |=> rdata_o == $past(cap_q[15:8], 3)) else $error("capture high mismatch");
  a_cmpa_pair: assert property (@(posedge clock_i) disable iff (!rst_b_i) // RULE15
    bus_wr(addr_i, ADDR_CMPA_LO, wr_i) |=> cmpa_q == {$past(temp_q), $past(wdata_i)})
    else $error("compare pair");
  a_match_flag: assert property (@(posedge clock_i) disable iff (!rst_b_i) // RULE14
    match_b |=> flags_q[2]) else $error("compare B flag missing");
  a_irq_cap: assert property (@(posedge clock_i) disable iff (!rst_b_i) // RULE16
    irq_req_o[3] |-> global_irq_en_i && mask_q[5] && flags_q[3]) else $error("capture irq");
  a_irq_b: assert property (@(posedge clock_i) disable iff (!rst_b_i) // RULE17
    global_irq_en_i && mask_q[2] && flags_q[2] |-> irq_req_o[2]) else $error("compare B irq");
  a_irq_ovf: assert property (@(posedge clock_i) disable iff (!rst_b_i) // RULE18
    irq_req_o[0] == (global_irq_en_i && mask_q[0] && flags_q[0])) else $error("ovf irq");
  a_flag_clear: assert property (@(posedge clock_i) disable iff (!rst_b_i) // RULE19
    irq_ack_i[1] && !flag_set[1] |=> !flags_q[1]) else $error("flag not cleared");
  a_ctc_top: assert property (@(posedge clock_i) disable iff (!rst_b_i) // RULE12
    wave_mode == WAVE_CTC_CAP |-> top == cap_q) else $error("capture top");

  // Counting, flag and pin checks judged from the state one cycle on.
  a_stop_frozen: assert property (@(posedge clock_i) disable iff (!rst_b_i) // RULE1
    clk_ctrl_q[2:0] == 3'h0 && !cnt_write |=> cnt_q == $past(cnt_q)) else $error("counter moved while stopped");
  a_div1_count: assert property (@(posedge clock_i) disable iff (!rst_b_i) // RULE2
    clk_ctrl_q[2:0] == 3'h1 && !cnt_write && !top_hit |=> cnt_q == $past(cnt_q) + 16'h0001)
    else $error("undivided count missed");
  a_force_no_clear: assert property (@(posedge clock_i) disable iff (!rst_b_i) // RULE6
    force_a && !tick && !cnt_write |=> cnt_q == $past(cnt_q)) else $error("force moved counter");
  a_force_pin_a: assert property (@(posedge clock_i) disable iff (!rst_b_i) // RULE5
    (match_a || force_a) && wave_ctrl_q[7:6] == 2'b01 |=> compare_output_pin_a_o != $past(compare_output_pin_a_o))
    else $error("channel A pin did not toggle");
  a_match_pin_b: assert property (@(posedge clock_i) disable iff (!rst_b_i) // RULE14
    (match_b || force_b) && wave_ctrl_q[5:4] == 2'b01 |=> compare_output_pin_b_o != $past(compare_output_pin_b_o))
    else $error("channel B pin did not toggle");
  a_set_wins: assert property (@(posedge clock_i) disable iff (!rst_b_i) // RULE19
    flag_set[3] && flag_clr[3] |=> flags_q[3]) else $error("clear beat capture event");
  a_ack_clears_cap: assert property (@(posedge clock_i) disable iff (!rst_b_i) // RULE19
    irq_ack_i[3] && !flag_set[3] |=> !flags_q[3]) else $error("capture flag not cleared");
  a_ovf_flag: assert property (@(posedge clock_i) disable iff (!rst_b_i) // RULE18
    ovf |=> flags_q[0]) else $error("overflow flag missing");
  a_cap_top_flag: assert property (@(posedge clock_i) disable iff (!rst_b_i) // RULE12
    cap_is_top && top_hit |=> flags_q[3]) else $error("capture flag missing at top");
  a_cap_top_clear: assert property (@(posedge clock_i) disable iff (!rst_b_i) // RULE12
    cap_is_top && top_hit && !cnt_write |=> cnt_q == 16'h0000) else $error("counter passed capture top");
  a_cmpb_pair: assert property (@(posedge clock_i) disable iff (!rst_b_i) // RULE15
    bus_wr(addr_i, ADDR_CMPB_LO, wr_i) |=> cmpb_q == {$past(temp_q), $past(wdata_i)})
    else $error("compare B pair");
  a_cnt_lo_latch: assert property (@(posedge clock_i) disable iff (!rst_b_i) // RULE8
    rd_i && !wr_i && addr_i == ADDR_CNT_LO |=> temp_q == $past(cnt_q[15:8]))
    else $error("counter high not latched");

  c_match_a: cover property (@(posedge clock_i) match_a);
  c_force_b: cover property (@(posedge clock_i) force_b);
  c_capture: cover property (@(posedge clock_i) cap_event);
  c_overflow: cover property (@(posedge clock_i) ovf);
  c_capture_top: cover property (@(posedge clock_i) cap_is_top && top_hit);
endmodule // tmr_regs

/* File: dv/tmr_cpu_model.sv */
`timescale 1ns/1ps
// Behavioural processor core making one byte access at a time on the register bus.
module tmr_cpu_model
(
  // Clock
  input wire logic clock_i,
  // Register bus
  output logic [7:0] addr_o,
  output logic [7:0] wdata_o,
  output logic wr_o,
  output logic rd_o,
  input wire logic [7:0] rdata_i
);
  initial
  begin
    addr_o = 8'h00;
    wdata_o = 8'h00;
    wr_o = 1'b0;
    rd_o = 1'b0;
  end

  // Released lines show the inverse of their last value, never a stale copy.
  task automatic release_bus();
    addr_o = ~addr_o;
    wdata_o = ~wdata_o;
  endtask

  task automatic wr8(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock_i);
    #1;
    addr_o = a;
    wdata_o = d;
    wr_o = 1'b1;
    @(posedge clock_i);
    #1;
    wr_o = 1'b0;
    release_bus();
  endtask

  task automatic rd8(input logic [7:0] a, output logic [7:0] d);
    @(posedge clock_i);
    #1;
    addr_o = a;
    rd_o = 1'b1;
    @(posedge clock_i);
    #1;
    rd_o = 1'b0;
    d = rdata_i;
    release_bus();
  endtask

  task automatic wr16(input logic [7:0] a, input logic [15:0] d);
    wr8(a + 8'h01, d[15:8]);
    wr8(a, d[7:0]);
  endtask

  task automatic rd16(input logic [7:0] a, output logic [15:0] d);
    rd8(a, d[7:0]);
    rd8(a + 8'h01, d[15:8]);
  endtask
endmodule // tmr_cpu_model

/* File: dv/tb_top.sv */
`timescale 1ns/1ps
module tb_top
  import tmr_pkg::*;
();
  localparam logic [7:0] REGS [12] = '{ADDR_IRQ_MASK, ADDR_FLAGS, ADDR_CLK_CTRL, ADDR_WAVE_CTRL,
    ADDR_FORCE_CTRL, ADDR_CNT_LO, ADDR_CNT_HI, ADDR_CAP_LO, ADDR_CAP_HI, ADDR_CMPA_LO, ADDR_CMPA_HI,
    ADDR_CMPB_LO};
  localparam logic [7:0] WIDE [4] = '{ADDR_CMPA_LO, ADDR_CMPB_LO, ADDR_CAP_LO, ADDR_CNT_LO};
  localparam int DIVS [5] = '{1, 8, 64, 256, 1024};
  logic clock_i, rst_b_i, ext_pin, cap_pin, comp, cap_src, gie, wr, rd, pin_a, pin_b;
  logic [3:0] ack, irq;
  logic [7:0] addr, wdata, rdata, clk_hi, r;
  logic [15:0] v;
  int num_errors, cmp_count, n;

  tmr_cpu_model u_cpu (.clock_i(clock_i), .addr_o(addr), .wdata_o(wdata), .wr_o(wr), .rd_o(rd),
    .rdata_i(rdata));

  tmr_regs u_dut (.clock_i(clock_i), .rst_b_i(rst_b_i), .addr_i(addr), .wdata_i(wdata), .wr_i(wr),
    .rd_i(rd), .rdata_o(rdata), .ext_count_pin_i(ext_pin), .capture_input_pin_i(cap_pin),
    .comparator_i(comp), .cap_from_comp_i(cap_src), .compare_output_pin_a_o(pin_a),
    .compare_output_pin_b_o(pin_b), .global_irq_en_i(gie), .irq_ack_i(ack), .irq_req_o(irq));

  task automatic final_report();
    if (num_errors == 0 && cmp_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      num_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic tick(input int k);
    repeat (k) @(posedge clock_i);
    #1;
  endtask

  task automatic exp8(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] b;
    u_cpu.rd8(a, b);
    chk({8'h00, b}, {8'h00, e});
  endtask

  task automatic exp16(input logic [7:0] a, input logic [15:0] e);
    logic [15:0] w;
    u_cpu.rd16(a, w);
    chk(w, e);
  endtask

  // A range is needed where the free-running prescaler phase is unknown.
  task automatic cnt_rng(input int lo, input int hi);
    logic [15:0] w;
    u_cpu.rd16(ADDR_CNT_LO, w);
    cmp_count++;
    if ($isunknown(w) || w < lo || w > hi)
    begin
      num_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h..%h", $time, w, lo, hi);
    end
  endtask

  task automatic set_cnt(input logic [15:0] d);
    u_cpu.wr16(ADDR_CNT_LO, d);
  endtask

  task automatic run(input logic [2:0] code, input int k);
    u_cpu.wr8(ADDR_CLK_CTRL, clk_hi | {5'h00, code});
    tick(k);
    u_cpu.wr8(ADDR_CLK_CTRL, clk_hi);
  endtask

  initial
  begin
    clock_i = 1'b0;
    forever #20 clock_i = ~clock_i;
  end

  initial
  begin
    #2400000;
    num_errors++;
    final_report();
  end

  initial
  begin
    rst_b_i = 1'b0;
    ext_pin = 1'b0;
    cap_pin = 1'b0;
    comp = 1'b0;
    cap_src = 1'b0;
    gie = 1'b0;
    ack = 4'h0;
    clk_hi = 8'h00;
    num_errors = 0;
    cmp_count = 0;
    void'($urandom(32'hD369));
    tick(4);
    rst_b_i = 1'b1;
    foreach (REGS[i])
      exp8(REGS[i], RESET_BYTE);
    u_cpu.wr8(8'h90, 8'hFF);
    exp8(8'h90, 8'h00);
    r = 8'($urandom);
    u_cpu.wr8(ADDR_IRQ_MASK, r);
    exp8(ADDR_IRQ_MASK, r & 8'h27);
    foreach (WIDE[i])
    begin
      v = 16'($urandom);
      u_cpu.wr16(WIDE[i], v);
      exp16(WIDE[i], v);
    end
    u_cpu.wr8(ADDR_IRQ_MASK, 8'h00);
    for (int c = 1; c <= 5; c++)
    begin
      set_cnt(16'h0000);
      run(3'(c), 4 * DIVS[c - 1]);
      cnt_rng(3, 7);
    end
    set_cnt(16'h0000);
    run(3'h0, 100);
    exp16(ADDR_CNT_LO, 16'h0000);
    for (int c = 6; c <= 7; c++)
    begin
      set_cnt(16'h0000);
      u_cpu.wr8(ADDR_CLK_CTRL, 8'(c));
      n = 0;
      repeat (9)
      begin
        tick(3);
        if ((c == 7) != ext_pin)
          n++;
        ext_pin = ~ext_pin;
      end
      tick(6);
      u_cpu.wr8(ADDR_CLK_CTRL, 8'h00);
      exp16(ADDR_CNT_LO, 16'(n));
    end
    clk_hi = 8'h08;
    u_cpu.wr8(ADDR_CLK_CTRL, clk_hi);
    set_cnt(16'h1234);
    u_cpu.wr16(ADDR_CMPA_LO, 16'h8000);
    u_cpu.wr8(ADDR_FLAGS, 8'h27);
    u_cpu.wr8(ADDR_WAVE_CTRL, 8'h50);
    u_cpu.wr8(ADDR_FORCE_CTRL, 8'h80);
    tick(3);
    chk({14'h0000, pin_a, pin_b}, 16'h0002);
    u_cpu.wr8(ADDR_FORCE_CTRL, 8'h40);
    tick(3);
    chk({14'h0000, pin_a, pin_b}, 16'h0003);
    exp8(ADDR_FORCE_CTRL, 8'h00);
    exp8(ADDR_FLAGS, 8'h00);
    exp16(ADDR_CNT_LO, 16'h1234);
    u_cpu.wr8(ADDR_WAVE_CTRL, 8'h51);
    u_cpu.wr8(ADDR_FORCE_CTRL, 8'hC0);
    tick(3);
    chk({14'h0000, pin_a, pin_b}, 16'h0003);
    u_cpu.wr8(ADDR_WAVE_CTRL, 8'h50);
    clk_hi = 8'h40;
    u_cpu.wr8(ADDR_CLK_CTRL, clk_hi);
    u_cpu.wr8(ADDR_IRQ_MASK, 8'h27);
    gie = 1'b1;
    for (int s = 0; s <= 1; s++)
    begin
      v = 16'($urandom);
      set_cnt(v);
      cap_src = s[0];
      tick(1);
      if (s == 0)
        cap_pin = 1'b1;
      else
        comp = 1'b1;
      tick(4);
      cap_pin = 1'b0;
      comp = 1'b0;
      tick(4);
      exp16(ADDR_CAP_LO, v);
      chk({12'h000, irq}, 16'h0008);
      if (s == 0)
      begin
        ack = 4'h8;
        tick(1);
        ack = 4'h0;
      end
      else
        u_cpu.wr8(ADDR_FLAGS, 8'h20);
      exp8(ADDR_FLAGS, 8'h00);
      chk({12'h000, irq}, 16'h0000);
    end
    gie = 1'b0;
    v = 16'h0100 + 16'($urandom_range(0, 32'hE000));
    set_cnt(v);
    u_cpu.wr16(ADDR_CMPB_LO, v + 16'h0003);
    u_cpu.wr16(ADDR_CMPA_LO, v + 16'h0005);
    run(3'h1, 20);
    exp8(ADDR_FLAGS, 8'h06);
    chk({14'h0000, pin_a, pin_b}, 16'h0000);
    chk({12'h000, irq}, 16'h0000);
    gie = 1'b1;
    tick(1);
    chk({12'h000, irq}, 16'h0006);
    u_cpu.wr8(ADDR_IRQ_MASK, 8'h04);
    chk({12'h000, irq}, 16'h0004);
    u_cpu.wr8(ADDR_FLAGS, 8'h06);
    exp8(ADDR_FLAGS, 8'h00);
    set_cnt(v + 16'h0003);
    run(3'h1, 20);
    exp8(ADDR_FLAGS, 8'h02);
    chk({14'h0000, pin_a, pin_b}, 16'h0002);
    u_cpu.wr8(ADDR_FLAGS, 8'h06);
    set_cnt(16'hFFF0);
    u_cpu.wr8(ADDR_IRQ_MASK, 8'h01);
    run(3'h1, 30);
    exp8(ADDR_FLAGS, 8'h01);
    chk({12'h000, irq}, 16'h0001);
    u_cpu.wr8(ADDR_FLAGS, 8'h01);
    u_cpu.wr16(ADDR_CAP_LO, 16'h0010);
    clk_hi = 8'h18;
    set_cnt(16'h0000);
    run(3'h1, 200);
    cnt_rng(0, 16);
    final_report();
  end
endmodule // tb_top
